// ---- hw/gfr_regs.vh ----
`ifndef GFR_REGS_VH
`define GFR_REGS_VH
// bus address of the chip on the two-wire link
`define GFR_DEV_ADDR 7'h2A
// register byte addresses
`define GFR_THR_OFF 8'hA0
`define GFR_CFG_OFF 8'hAB
`define GFR_LVL_OFF 8'hAE
`define GFR_STAT_OFF 8'hAF
`define GFR_FORCE_OFF 8'hE4
`define GFR_PCLR_OFF 8'hE5
`define GFR_LCLR_OFF 8'hE6
`define GFR_ACLR_OFF 8'hE7
`define GFR_UP_OFF 8'hFC
`define GFR_DOWN_OFF 8'hFD
`define GFR_LEFT_OFF 8'hFE
`define GFR_RIGHT_OFF 8'hFF
// field positions
`define GFR_STAT_VALID 0
`define GFR_STAT_OVF 1
`define GFR_CFG_RUN 0
`define GFR_CFG_UNMASK 1
`define GFR_CFG_CLR 2
// reset values
`define GFR_THR_RST 8'h00
`define GFR_PTR_RST 8'h00
// fifo geometry
`define GFR_DS_WIDTH 32
`define GFR_DS_DEPTH 32
`define GFR_DS_AW 5
`endif

// ---- hw/gfr_top.v ----
`timescale 1ns/100ps
`include "gfr_regs.vh"

////////////////////////////////////////////////////////////////////////
// dataset buffer: plain circular fifo with occupancy count
module gfr_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // clock and reset
   input wire clk_in,
   input wire rst_b_in,
   input wire clear_in,
   // filling side
   input wire wr_valid_in,
   input wire [WIDTH-1:0] wr_data_in,
   output wire wr_ready_out,
   // draining side
   output wire rd_valid_out,
   input wire rd_ready_in,
   output wire [WIDTH-1:0] rd_data_out,
   output wire [AW:0] level_out
);
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // full refuses the write so stored datasets are never overwritten
   assign wr_ready_out = (count != FULL_CNT);
   assign rd_valid_out = (count != {(AW+1){1'b0}});
   assign push = wr_valid_in & wr_ready_out;
   assign pop = rd_ready_in & rd_valid_out;
   assign rd_data_out = mem[rd_ptr];
   assign level_out = count;

   // storage has no reset; only pointers and count carry meaning
   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= wr_data_in;
      end
   end

   // pointers wrap on their own since depth is a power of two
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (clear_in) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
// gesture fifo read-out behind a two-wire slave port
module gfr_top (
   // clock and reset
   input wire clk_in,
   input wire rst_b_in,
   // two-wire link, data pin is open drain
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_out,
   // interrupt pin, open drain, pulled low while pending
   output wire int_out,
   output wire int_oe_out,
   // datasets from the gesture engine: up, down, left, right msb first
   input wire ds_valid_in,
   input wire [31:0] ds_data_in,
   output wire ds_ready_out,
   // gesture engine and other sensor events
   input wire gesture_entry_in,
   input wire gesture_exit_in,
   input wire prox_event_in,
   input wire light_event_in,
   output wire gesture_running_out
);
   // link states, one hot
   localparam [7:0] S_IDLE = 8'h01;
   localparam [7:0] S_ADDR = 8'h02;
   localparam [7:0] S_ACKA = 8'h04;
   localparam [7:0] S_REG = 8'h08;
   localparam [7:0] S_ACKR = 8'h10;
   localparam [7:0] S_WDAT = 8'h20;
   localparam [7:0] S_ACKW = 8'h40;
   localparam [7:0] S_RACK = 8'h80;

   reg scl_s1, scl_s2, scl_s3;
   reg sda_s1, sda_s2, sda_s3;
   reg [7:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg [7:0] tx;
   reg [7:0] ptr;
   reg rw;
   reg drive_low;
   reg [7:0] threshold;
   reg irq_unmask;
   reg running;
   reg valid_flag;
   reg ovf_flag;
   reg gesture_interrupt;
   reg prox_irq;
   reg light_irq;
   reg force_irq;
   reg [7:0] rd_byte;
   wire scl_rise, scl_fall, start_cond, stop_cond;
   wire acc_hit, wr_hit, load_en, pop, fifo_clear, drop, above;
   wire [7:0] next_ptr;
   wire [7:0] level;
   wire [5:0] fifo_level;
   wire [31:0] head;
   wire head_valid;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second and third stages are read
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // line events; start and stop are data edges while clock is high
   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_cond = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // register pointer steps; the data window loops for page reads
   assign next_ptr = (ptr == `GFR_RIGHT_OFF) ? `GFR_UP_OFF :
      ptr + 8'h01;

   // strobes: register byte done, data byte done, read byte loaded
   assign acc_hit = (state == S_REG) & scl_fall & (bit_cnt == 4'h8);
   assign wr_hit = (state == S_WDAT) & scl_fall & (bit_cnt == 4'h8);
   assign load_en = scl_fall & (((state == S_ACKA) & rw) |
      (state == S_RACK));

   ////////////////////////////////////////////////////////////////////
   // slave sequencer
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         ptr <= `GFR_PTR_RST;
         rw <= 1'b0;
         drive_low <= 1'b0;
      end else if (start_cond) begin
         state <= S_ADDR;
         bit_cnt <= 4'h0;
         drive_low <= 1'b0;
      end else if (stop_cond) begin
         state <= S_IDLE;
         drive_low <= 1'b0;
      end else begin
         // shared read-byte load: first byte after address or after ack
         if (load_en) begin
            tx <= rd_byte;
            drive_low <= ~rd_byte[7];
            bit_cnt <= 4'h1;
            ptr <= next_ptr;
            state <= S_WDAT;
         end
         case (state)
            S_IDLE: begin
               drive_low <= 1'b0;
            end
            S_ADDR, S_REG, S_WDAT: begin
               if (scl_rise && (state != S_WDAT || !rw)) begin
                  shift <= {shift[6:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               // a read transfer reuses the data state for sending
               if (scl_fall && state == S_WDAT && rw) begin
                  if (bit_cnt == 4'h8) begin
                     drive_low <= 1'b0;
                     state <= S_RACK;
                  end else begin
                     drive_low <= ~tx[6];
                     tx <= {tx[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (state == S_ADDR) begin
                     if (shift[7:1] == `GFR_DEV_ADDR) begin
                        rw <= shift[0];
                        drive_low <= 1'b1;
                        state <= S_ACKA;
                     end else begin
                        state <= S_IDLE;
                     end
                  end else if (state == S_REG) begin
                     ptr <= shift;
                     drive_low <= 1'b1;
                     state <= S_ACKR;
                  end else begin
                     ptr <= next_ptr;
                     drive_low <= 1'b1;
                     state <= S_ACKW;
                  end
               end
            end
            S_ACKA: begin
               if (scl_fall && !rw) begin
                  drive_low <= 1'b0;
                  bit_cnt <= 4'h0;
                  state <= S_REG;
               end
            end
            S_ACKR, S_ACKW: begin
               if (scl_fall) begin
                  drive_low <= 1'b0;
                  bit_cnt <= 4'h0;
                  rw <= 1'b0;
                  state <= S_WDAT;
               end
            end
            S_RACK: begin
               // host nack ends the read; wait for stop or start
               if (scl_rise && sda_s2) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
               drive_low <= 1'b0;
            end
         endcase
      end
   end

   // the pin is only ever pulled low, never driven high
   assign sda_out = 1'b0;
   assign sda_oe_out = drive_low;

   ////////////////////////////////////////////////////////////////////
   // read data mux; fifo window reads zero once the fifo is empty
   assign level = {2'b00, fifo_level};
   always @* begin
      rd_byte = 8'h00;
      case (ptr)
         `GFR_THR_OFF: rd_byte = threshold;
         `GFR_CFG_OFF: rd_byte = {6'h00, irq_unmask, running};
         `GFR_LVL_OFF: rd_byte = level;
         `GFR_STAT_OFF: rd_byte = {6'h00, ovf_flag, valid_flag};
         `GFR_UP_OFF: rd_byte = head_valid ? head[31:24] : 8'h00;
         `GFR_DOWN_OFF: rd_byte = head_valid ? head[23:16] : 8'h00;
         `GFR_LEFT_OFF: rd_byte = head_valid ? head[15:8] : 8'h00;
         `GFR_RIGHT_OFF: rd_byte = head_valid ? head[7:0] : 8'h00;
         default: rd_byte = 8'h00;
      endcase
   end

   // pop only as the right byte leaves, and only with data stored
   assign pop = load_en & (ptr == `GFR_RIGHT_OFF) & head_valid;
   assign fifo_clear = wr_hit & (ptr == `GFR_CFG_OFF) &
      shift[`GFR_CFG_CLR];
   assign drop = ds_valid_in & ~ds_ready_out;
   assign above = (level > threshold);

   ////////////////////////////////////////////////////////////////////
   // dataset storage
   gfr_fifo #(
      .WIDTH(`GFR_DS_WIDTH),
      .DEPTH(`GFR_DS_DEPTH),
      .AW(`GFR_DS_AW)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .clear_in(fifo_clear),
      .wr_valid_in(ds_valid_in),
      .wr_data_in(ds_data_in),
      .wr_ready_out(ds_ready_out),
      .rd_valid_out(head_valid),
      .rd_ready_in(pop),
      .rd_data_out(head),
      .level_out(fifo_level)
   );

   ////////////////////////////////////////////////////////////////////
   // writable control registers
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         threshold <= `GFR_THR_RST;
         irq_unmask <= 1'b0;
         running <= 1'b0;
      end else begin
         if (wr_hit && ptr == `GFR_THR_OFF) begin
            threshold <= shift;
         end
         if (wr_hit && ptr == `GFR_CFG_OFF) begin
            irq_unmask <= shift[`GFR_CFG_UNMASK];
            running <= shift[`GFR_CFG_RUN];
         end else if (gesture_entry_in) begin
            running <= 1'b1;
         end else if (gesture_exit_in) begin
            running <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // gesture flags; a drop outranks the clear for ovf_flag, but the clear outranks above for the other two
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         valid_flag <= 1'b0;
         ovf_flag <= 1'b0;
         gesture_interrupt <= 1'b0;
      end else begin
         if (drop) begin
            ovf_flag <= 1'b1;
         end else if (fifo_clear) begin
            ovf_flag <= 1'b0;
         end
         if (above && !fifo_clear) begin
            valid_flag <= 1'b1;
         end else if (fifo_clear || (!running && level == 8'h00)) begin
            valid_flag <= 1'b0;
         end
         // stays up while data remains, so late arrivals keep it set
         if (above && !fifo_clear) begin
            gesture_interrupt <= 1'b1;
         end else if (fifo_clear || level == 8'h00) begin
            gesture_interrupt <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // address-only accesses act at the register byte, no data needed
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prox_irq <= 1'b0;
         light_irq <= 1'b0;
         force_irq <= 1'b0;
      end else begin
         if (prox_event_in) begin
            prox_irq <= 1'b1;
         end else if (acc_hit && (shift == `GFR_PCLR_OFF ||
               shift == `GFR_ACLR_OFF)) begin
            prox_irq <= 1'b0;
         end
         if (light_event_in) begin
            light_irq <= 1'b1;
         end else if (acc_hit && (shift == `GFR_LCLR_OFF ||
               shift == `GFR_ACLR_OFF)) begin
            light_irq <= 1'b0;
         end
         if (acc_hit && shift == `GFR_FORCE_OFF) begin
            force_irq <= 1'b1;
         end else if (acc_hit && shift == `GFR_ACLR_OFF) begin
            force_irq <= 1'b0;
         end
      end
   end

   // open-drain interrupt: pull low while prox, light or force is pending, or the gesture source with irq_unmask set
   assign int_out = 1'b0;
   assign int_oe_out = (gesture_interrupt & irq_unmask) | prox_irq | light_irq |
      force_irq;
   assign gesture_running_out = running;
endmodule

// ---- testbench/gfr_host.sv ----
`timescale 1ns/100ps
`include "gfr_regs.vh"
////////////////////////////////////////////////////////////////////////
// two-wire host model; never stretches, pulls data low on sda_oe_out
module gfr_host (
   // clock
   input wire clk_in,
   // link pins
   input wire sda_in,
   output reg scl_out,
   output reg sda_oe_out
);
   reg [7:0] rbuf [0:127];
   reg [7:0] junk;
   reg ack;
   integer nak;
   // idle bus: clock high, data released
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
      nak = 0;
   end
   // 8 clocks a phase, twice the floor the slave needs to see an edge
   task ph;
      repeat (8) @(negedge clk_in);
   endtask
   // data moves mid low phase, so it never races the falling clock
   task bitx(input w, output r);
      sda_oe_out = !w;
      ph;
      scl_out = 1'b1;
      ph;
      r = sda_in;
      scl_out = 1'b0;
      ph;
   endtask
   task xfer(input [7:0] w, input aw, output [7:0] r);
      for (int i = 7; i >= 0; i--)
         bitx(w[i], r[i]);
      bitx(aw, ack);
   endtask
   // one byte out, a missing acknowledge is counted
   task sendb(input [7:0] b);
      xfer(b, 1'b1, junk);
      if (ack !== 1'b0)
         nak++;
   endtask
   // start or repeated start: data falls while clock high
   task start;
      sda_oe_out = 1'b0;
      scl_out = 1'b1;
      ph;
      sda_oe_out = 1'b1;
      ph;
      scl_out = 1'b0;
      ph;
   endtask
   // stop: data rises while clock high
   task stop;
      sda_oe_out = 1'b1;
      ph;
      scl_out = 1'b1;
      ph;
      sda_oe_out = 1'b0;
      ph;
   endtask
   // pointer write; without a data byte it is an address-only access
   task wr(input [7:0] ra, input [7:0] d, input with_data);
      start;
      sendb({`GFR_DEV_ADDR, 1'b0});
      sendb(ra);
      if (with_data)
         sendb(d);
      stop;
   endtask
   // pointer write, repeated start, n bytes, last one not acknowledged
   task rd(input [7:0] ra, input int n);
      start;
      sendb({`GFR_DEV_ADDR, 1'b0});
      sendb(ra);
      start;
      sendb({`GFR_DEV_ADDR, 1'b1});
      for (int i = 0; i < n; i++)
         xfer(8'hFF, i == n - 1, rbuf[i]);
      stop;
   endtask
endmodule

// ---- testbench/gfr_top_sva.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// port checker: data drive, interrupt pin, fill side, running flag
module gfr_sva (
   // clock and reset
   input wire clk_in,
   input wire rst_b_in,
   // pins and side ports
   input wire scl_in,
   input wire sda_oe_out,
   input wire int_oe_out,
   input wire ds_valid_in,
   input wire ds_ready_out,
   input wire prox_event_in,
   input wire light_event_in,
   input wire gesture_entry_in,
   input wire gesture_running_out
);
   reg [3:0] hi_cnt;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // link clock high time, saturating; clears only follow link edges,
   // so none may land deep in an idle stretch
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         hi_cnt <= 4'h0;
      else if (!scl_in)
         hi_cnt <= 4'h0;
      else if (hi_cnt != 4'hF)
         hi_cnt <= hi_cnt + 4'h1;
   end
   sequence s_link_busy;
      $past(hi_cnt) < 4'hE;
   endsequence
   sda_stable_a: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data drive moved while link clock high");
   idle_release_a: assert property (hi_cnt == 4'hF |-> !sda_oe_out)
      else $error("data line held on an idle link");
   full_cause_a:
      assert property ($fell(ds_ready_out) |-> $past(ds_valid_in))
      else $error("fifo filled with no dataset offered");
   full_hold_a: assert property ($rose(ds_ready_out) |-> s_link_busy)
      else $error("full fifo freed without a read");
   prox_irq_a: assert property (prox_event_in |=> int_oe_out)
      else $error("proximity event left pin idle");
   light_irq_a: assert property (light_event_in |=> int_oe_out)
      else $error("light event left pin idle");
   quiet_hold_a: assert property ($fell(int_oe_out) |-> s_link_busy)
      else $error("interrupt dropped without link traffic");
   run_set_a: assert property (gesture_entry_in |=> gesture_running_out)
      else $error("entry did not set running flag");
endmodule

bind gfr_top gfr_sva chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .scl_in(scl_in), .sda_oe_out(sda_oe_out), .int_oe_out(int_oe_out),
   .ds_valid_in(ds_valid_in), .ds_ready_out(ds_ready_out),
   .prox_event_in(prox_event_in), .light_event_in(light_event_in),
   .gesture_entry_in(gesture_entry_in),
   .gesture_running_out(gesture_running_out));

// ---- testbench/tb_gfr_top.sv ----
`timescale 1ns/100ps
`include "gfr_regs.vh"
////////////////////////////////////////////////////////////////////////
// bench: host model on the link, datasets and events driven here
module tb_gfr_top;
   reg clk_in;
   reg rst_b_in;
   reg ds_valid;
   reg [31:0] ds_data;
   reg prox, light, entry, leave;
   wire scl, h_oe, sda_oe, sda_w, int_oe, ds_ready, running;
   // pin values of the open-drain outputs, low whenever enabled
   wire sda_o, int_o;
   integer n_mismatch, cmp_count, k;
   // pull-up on the data line unless a side pulls it low
   assign sda_w = !(h_oe | sda_oe);
   gfr_host host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl),
      .sda_oe_out(h_oe));
   gfr_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .int_out(int_o),
      .int_oe_out(int_oe), .ds_valid_in(ds_valid), .ds_data_in(ds_data),
      .ds_ready_out(ds_ready), .gesture_entry_in(entry),
      .gesture_exit_in(leave), .prox_event_in(prox),
      .light_event_in(light), .gesture_running_out(running));
   ////////////////////////////////////////////////////////////////////
   task close_out;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t seen %h want %h", $time, got, exp);
      end
   endtask
   // byte b of dataset n: up, down, left, right from the msb down
   function [7:0] byt(input [7:0] n, input int b);
      reg [31:0] v;
      v = {n, n ^ 8'h5A, n + 8'h80, ~n};
      byt = v[31 - 8 * b -: 8];
   endfunction
   // one-cycle pulses on {prox, light, entry, leave}
   task ev(input [3:0] m);
      {prox, light, entry, leave} = m;
      @(negedge clk_in);
      {prox, light, entry, leave} = 4'h0;
   endtask
   task push(input [7:0] n);
      ds_data = {byt(n, 0), byt(n, 1), byt(n, 2), byt(n, 3)};
      ds_valid = 1'b1;
      @(negedge clk_in);
      ds_valid = 1'b0;
      repeat (3) @(negedge clk_in);
   endtask
   // single read; status bits 7:2 carry no meaning, so they are masked
   task rdc(input [7:0] ra, input [7:0] exp);
      host.rd(ra, 1);
      chk(ra == `GFR_STAT_OFF ? host.rbuf[0] & 8'h03 : host.rbuf[0], exp);
   endtask
   // page read of n sets from the up byte; zero for an empty fifo
   task page(input int n, input [7:0] a, input zero);
      host.rd(`GFR_UP_OFF, 4 * n);
      for (int j = 0; j < 4 * n; j++)
         chk(host.rbuf[j], zero ? 8'h00 : byt(8'(a + j / 4), j % 4));
   endtask
   ////////////////////////////////////////////////////////////////////
   // sticky events against the three address-only clears and a force write with a data byte
   task t_irq;
      ev(4'h8);
      chk(int_oe, 1'b1);
      host.wr(`GFR_PCLR_OFF, 8'h00, 1'b0);
      chk(int_oe, 1'b0);
      ev(4'hC);
      host.wr(`GFR_LCLR_OFF, 8'h00, 1'b0);
      chk(int_oe, 1'b1);
      host.wr(`GFR_PCLR_OFF, 8'h00, 1'b0);
      chk(int_oe, 1'b0);
      host.wr(`GFR_FORCE_OFF, 8'hC3, 1'b1);
      chk(int_oe, 1'b1);
      ev(4'hC);
      host.wr(`GFR_ACLR_OFF, 8'h00, 1'b0);
      chk(int_oe, 1'b0);
   endtask
   // threshold edge, single-byte reads, refill while draining
   task t_single;
      host.wr(`GFR_THR_OFF, 8'h01, 1'b1);
      host.wr(`GFR_CFG_OFF, 8'h02, 1'b1);
      ev(4'h2);
      chk(running, 1'b1);
      rdc(`GFR_CFG_OFF, 8'h03);
      rdc(`GFR_THR_OFF, 8'h01);
      push(8'h01);
      chk(int_oe, 1'b0);
      rdc(`GFR_STAT_OFF, 8'h00);
      push(8'h02);
      chk(int_oe, 1'b1);
      rdc(`GFR_STAT_OFF, 8'h01);
      for (k = 0; k < 3; k++)
         rdc(8'(`GFR_UP_OFF + k), byt(8'h01, k));
      rdc(`GFR_LVL_OFF, 8'h02);
      rdc(`GFR_RIGHT_OFF, byt(8'h01, 3));
      rdc(`GFR_LVL_OFF, 8'h01);
      push(8'h03);
      page(1, 8'h02, 1'b0);
      chk(int_oe, 1'b1);
      page(1, 8'h03, 1'b0);
      rdc(`GFR_LVL_OFF, 8'h00);
      chk(int_oe, 1'b0);
      rdc(`GFR_STAT_OFF, 8'h01);
   endtask
   // 33 sets into 32 places, full drain, empty reads, fifo clear
   task t_fill;
      host.wr(`GFR_THR_OFF, 8'h00, 1'b1);
      for (k = 0; k < 33; k++) begin
         chk(ds_ready, k < 32);
         push(8'(k + 16));
      end
      rdc(`GFR_STAT_OFF, 8'h03);
      rdc(`GFR_LVL_OFF, 8'h20);
      page(32, 8'h10, 1'b0);
      chk(ds_ready, 1'b1);
      chk(int_oe, 1'b0);
      ev(4'h1);
      rdc(`GFR_STAT_OFF, 8'h02);
      page(1, 8'h00, 1'b1);
      rdc(`GFR_LVL_OFF, 8'h00);
      push(8'h07);
      host.wr(`GFR_CFG_OFF, 8'h06, 1'b1);
      rdc(`GFR_STAT_OFF, 8'h00);
      rdc(`GFR_LVL_OFF, 8'h00);
      chk(int_oe, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = !clk_in;
   end
   // reset, then the scenarios; the link waits out the synchroniser
   initial begin
      {rst_b_in, ds_valid, prox, light, entry, leave} = 6'h00;
      ds_data = 32'h0000_0000;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (3) @(negedge clk_in);
      chk({ds_ready, int_oe, running, sda_oe, sda_o, int_o}, 6'h20);
      rst_b_in = 1'b1;
      repeat (3) @(negedge clk_in);
      t_irq;
      t_single;
      t_fill;
      chk(host.nak, 0);
      close_out;
   end
   // a hang counts as a mismatch and ends the run
   initial begin
      repeat (95000) @(posedge clk_in);
      n_mismatch++;
      close_out;
   end
endmodule
